// ### verilog/osfm_cfg.svh
// Constants for the superframe sequencer and subcarrier classifier.
// Assumes inclusion by bare name; definitions only.
`ifndef OSFM_CFG_SVH
`define OSFM_CFG_SVH
// Register offsets (word index equals byte address / 1, plain port)
`define OSFM_ADDR_CTRL 4'h0
`define OSFM_ADDR_SECTOR 4'h1
`define OSFM_ADDR_FRAMES 4'h2
`define OSFM_ADDR_BURST 4'h3
`define OSFM_ADDR_GUARD 4'h4
`define OSFM_ADDR_FFT 4'h5
`define OSFM_ADDR_CP 4'h6
`define OSFM_ADDR_SYMS 4'h7
`define OSFM_ADDR_RFRAME 4'h8
`define OSFM_ADDR_TGUARD 4'h9
`define OSFM_ADDR_STAT0 4'hA
`define OSFM_ADDR_STAT1 4'hB
// Control fields
`define OSFM_CTRL_EN_BIT 0
`define OSFM_CTRL_TDD_BIT 1
`define OSFM_CTRL_MC_BIT 2
// Reset values
`define OSFM_RST_FFT 13'h0200
`define OSFM_RST_NCAR 4'h1
`define OSFM_RST_FRAMES 6'h18
`define OSFM_RST_FLB 6'h01
`define OSFM_RST_RLB 6'h01
`define OSFM_RST_GUARD 12'h040
`define OSFM_RST_GPR 12'h040
`define OSFM_RST_CP 12'h040
`define OSFM_RST_CPPR 12'h040
`define OSFM_RST_WGI 12'h010
`define OSFM_RST_NPRE 4'h8
`define OSFM_RST_NSYM 4'h8
`define OSFM_RST_RFLEN 16'h1000
`define OSFM_RST_TGF 16'h0100
`define OSFM_RST_TGR 16'h0100
`endif

// ### verilog/osfm_pkg.sv
// Types shared by the sequencer and its helpers.
// Assumes osfm_cfg.svh is on the include path.
package osfm_pkg;
	typedef enum logic [2:0] {
		OSFM_PRE,
		OSFM_FWD,
		OSFM_MUTE_RL,
		OSFM_MUTE_GF
	} osfm_phase_e;
	typedef logic [11:0] osfm_sector_t;
endpackage : osfm_pkg

// ### verilog/osfm_symtimer.sv
// Chip counter over one OFDM symbol: data + prefix + one windowed guard.
// Assumes the length inputs are held stable while running.
`timescale 1ns/1ps
module osfm_symtimer import osfm_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [12:0] fft_len,
	input wire logic [11:0] cp_len,
	input wire logic [11:0] wgi_len,
	output logic [15:0] chip,
	output logic in_data,
	output logic sym_end
);
	logic [15:0] next_chip;
	logic [15:0] sym_len;
	////////////////////////////////////////////////////////////////
	// Symbol length and the data window after the prefix
	always_comb begin
		sym_len = 16'({3'h0, fft_len}) + 16'({4'h0, cp_len}) + 16'({4'h0, wgi_len});
		sym_end = run && (chip == sym_len - 16'h0001);
		in_data = run && (chip >= 16'({4'h0, cp_len})) && (chip < 16'({4'h0, cp_len}) + 16'({3'h0, fft_len}));
		next_chip = chip;
		if (!run) begin
			next_chip = 16'h0000;
		end else if (sym_end) begin
			next_chip = 16'h0000;
		end else begin
			next_chip = chip + 16'h0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chip <= 16'h0000;
		end else begin
			chip <= next_chip;
		end
	end
endmodule : osfm_symtimer

// ### verilog/osfm_classify.sv
// Combinational subcarrier classifier: carrier number, local index, guard
// and quasi-guard flags. Assumes carrier count is a power of two.
`timescale 1ns/1ps
module osfm_classify import osfm_pkg::*; (
	input wire logic [12:0] sc,
	input wire logic [12:0] fft_len,
	input wire logic [3:0] ncar_log2,
	input wire logic multi_carrier_enabled,
	input wire logic preamble,
	input wire logic [11:0] guard_pr,
	input wire logic [11:0] guard_fr,
	output logic [3:0] carrier_number,
	output logic [12:0] local_sc,
	output logic is_guard,
	output logic is_qguard
);
	logic [12:0] csize;
	logic [12:0] half;
	logic [12:0] qlo;
	logic [12:0] qhi;
	logic [12:0] off;
	////////////////////////////////////////////////////////////////
	// Carrier split and boundary distance
	always_comb begin
		csize = multi_carrier_enabled ? (fft_len >> ncar_log2) : fft_len;
		carrier_number = multi_carrier_enabled ? 4'((sc >> ncar_log2 == 13'h0000) ? 13'h0000 : (sc / csize)) : 4'h0;
		local_sc = sc - 13'(carrier_number * csize);
		half = preamble ? 13'({1'b0, guard_pr} >> 1) : 13'({1'b0, guard_fr} >> 1);
		is_guard = (sc < half) || (sc >= fft_len - half);
		// Preamble quasi-guard spans the full count each side, frames half
		qlo = preamble ? 13'({1'b0, guard_pr}) : half;
		qhi = qlo;
		off = local_sc;
		is_qguard = multi_carrier_enabled && !is_guard && (((off < qhi) && (carrier_number != 4'h0)) ||
			((off >= csize - qlo) && (32'(carrier_number) + 1 < (32'h1 << ncar_log2))));
	end
endmodule : osfm_classify

// ### verilog/osfm_superframe.sv
// Superframe sequencer and subcarrier mapper for a sector transmitter.
// Assumes a register master with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
`include "osfm_cfg.svh"
module osfm_superframe import osfm_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic sf_start,
	output logic [31:0] sf_index,
	output logic [11:0] superframe_phase_value,
	output logic in_preamble,
	output logic fwd_active,
	output logic mute,
	output logic [5:0] frame_number,
	output logic [3:0] symbol_number,
	output logic [12:0] subcarrier,
	output logic [3:0] carrier_number,
	output logic [12:0] local_subcarrier,
	output logic sc_valid,
	output logic sc_guard,
	output logic sc_qguard,
	output logic sc_usable,
	output logic sc_zero
);
	// Configuration
	logic enable;
	logic tdd_mode;
	logic multi_carrier_enabled;
	osfm_sector_t sector_identifier;
	logic [5:0] frame_total;
	logic [5:0] forward_burst_frame_count;
	logic [5:0] reverse_burst_frame_count;
	logic [11:0] guard_count_parameter;
	logic [11:0] preamble_guard_count;
	logic [12:0] transform_size;
	logic [3:0] ncar_log2;
	logic [11:0] cyclic_prefix_parameter;
	logic [11:0] prefix_pr;
	logic [11:0] windowed_guard_time;
	logic [3:0] pre_syms;
	logic [3:0] frame_syms;
	logic [15:0] rframe_len;
	logic [15:0] tg_fwd;
	logic [15:0] tg_rev;
	// Sequencer state
	osfm_phase_e phase, next_phase;
	logic [31:0] next_sf_index;
	logic [5:0] next_frame_number;
	logic [5:0] burst_cnt, next_burst_cnt;
	logic [5:0] rl_cnt, next_rl_cnt;
	logic [3:0] next_symbol_number;
	logic [15:0] mute_cnt, next_mute_cnt;
	logic next_sf_start;
	logic [31:0] next_rdata;
	// Timer and classifier wires
	logic run;
	logic [15:0] chip;
	logic in_data;
	logic sym_end;
	logic [12:0] cur_sc;
	logic [3:0] cls_car;
	logic [12:0] cls_local;
	logic cls_guard;
	logic cls_qguard;

	function automatic logic [11:0] phase_of(input logic [11:0] sec, input logic [31:0] idx);
		phase_of = sec + idx[11:0];
	endfunction : phase_of

	////////////////////////////////////////////////////////////////
	// Register writes; the first field of each word sits in its low bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			enable <= 1'b0;
			tdd_mode <= 1'b0;
			multi_carrier_enabled <= 1'b0;
			sector_identifier <= 12'h000;
			frame_total <= `OSFM_RST_FRAMES;
			forward_burst_frame_count <= `OSFM_RST_FLB;
			reverse_burst_frame_count <= `OSFM_RST_RLB;
			guard_count_parameter <= `OSFM_RST_GUARD;
			preamble_guard_count <= `OSFM_RST_GPR;
			transform_size <= `OSFM_RST_FFT;
			ncar_log2 <= 4'h0;
			cyclic_prefix_parameter <= `OSFM_RST_CP;
			prefix_pr <= `OSFM_RST_CPPR;
			windowed_guard_time <= `OSFM_RST_WGI;
			pre_syms <= `OSFM_RST_NPRE;
			frame_syms <= `OSFM_RST_NSYM;
			rframe_len <= `OSFM_RST_RFLEN;
			tg_fwd <= `OSFM_RST_TGF;
			tg_rev <= `OSFM_RST_TGR;
		end else if (reg_wr) begin
			case (reg_addr)
				`OSFM_ADDR_CTRL: begin
					enable <= reg_wdata[`OSFM_CTRL_EN_BIT];
					tdd_mode <= reg_wdata[`OSFM_CTRL_TDD_BIT];
					multi_carrier_enabled <= reg_wdata[`OSFM_CTRL_MC_BIT];
					ncar_log2 <= reg_wdata[7:4];
				end
				`OSFM_ADDR_SECTOR: sector_identifier <= reg_wdata[11:0];
				`OSFM_ADDR_FRAMES: frame_total <= reg_wdata[5:0];
				`OSFM_ADDR_BURST: begin
					forward_burst_frame_count <= reg_wdata[5:0];
					reverse_burst_frame_count <= reg_wdata[13:8];
				end
				`OSFM_ADDR_GUARD: begin
					guard_count_parameter <= reg_wdata[11:0];
					preamble_guard_count <= reg_wdata[27:16];
				end
				`OSFM_ADDR_FFT: transform_size <= reg_wdata[12:0];
				`OSFM_ADDR_CP: begin
					cyclic_prefix_parameter <= reg_wdata[11:0];
					prefix_pr <= reg_wdata[27:16];
				end
				`OSFM_ADDR_SYMS: begin
					pre_syms <= reg_wdata[3:0];
					frame_syms <= reg_wdata[7:4];
					windowed_guard_time <= reg_wdata[27:16];
				end
				`OSFM_ADDR_RFRAME: rframe_len <= reg_wdata[15:0];
				`OSFM_ADDR_TGUARD: begin
					tg_fwd <= reg_wdata[15:0];
					tg_rev <= reg_wdata[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses answer zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				`OSFM_ADDR_CTRL: next_rdata = {24'h000000, ncar_log2, 1'b0, multi_carrier_enabled, tdd_mode, enable};
				`OSFM_ADDR_SECTOR: next_rdata = {20'h00000, sector_identifier};
				`OSFM_ADDR_FRAMES: next_rdata = {26'h0000000, frame_total};
				`OSFM_ADDR_BURST: next_rdata = {18'h00000, reverse_burst_frame_count, 2'h0, forward_burst_frame_count};
				`OSFM_ADDR_GUARD: next_rdata = {4'h0, preamble_guard_count, 4'h0, guard_count_parameter};
				`OSFM_ADDR_FFT: next_rdata = {19'h00000, transform_size};
				`OSFM_ADDR_CP: next_rdata = {4'h0, prefix_pr, 4'h0, cyclic_prefix_parameter};
				`OSFM_ADDR_SYMS: next_rdata = {4'h0, windowed_guard_time, 8'h00, frame_syms, pre_syms};
				`OSFM_ADDR_RFRAME: next_rdata = {16'h0000, rframe_len};
				`OSFM_ADDR_TGUARD: next_rdata = {tg_rev, tg_fwd};
				`OSFM_ADDR_STAT0: next_rdata = sf_index;
				`OSFM_ADDR_STAT1: next_rdata = {10'h000, mute, in_preamble, symbol_number, frame_number,
					superframe_phase_value[9:0]};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Symbol timer; mute intervals keep it idle, prefix differs in preamble
	assign run = enable && (phase == OSFM_PRE || phase == OSFM_FWD);
	osfm_symtimer u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(run),
		.fft_len(transform_size),
		.cp_len(phase == OSFM_PRE ? prefix_pr : cyclic_prefix_parameter),
		.wgi_len(windowed_guard_time),
		.chip(chip),
		.in_data(in_data),
		.sym_end(sym_end)
	);

	// Subcarrier index during the data part of a symbol
	assign cur_sc = 13'(chip - 16'({4'h0, (phase == OSFM_PRE ? prefix_pr : cyclic_prefix_parameter)}));

	osfm_classify u_class (
		.sc(cur_sc),
		.fft_len(transform_size),
		.ncar_log2(ncar_log2),
		.multi_carrier_enabled(multi_carrier_enabled),
		.preamble(phase == OSFM_PRE),
		.guard_pr(preamble_guard_count),
		.guard_fr(guard_count_parameter),
		.carrier_number(cls_car),
		.local_sc(cls_local),
		.is_guard(cls_guard),
		.is_qguard(cls_qguard)
	);

	////////////////////////////////////////////////////////////////
	// Superframe sequencer: preamble, frames, TDD mutes
	always_comb begin
		next_phase = phase;
		next_sf_index = sf_index;
		next_frame_number = frame_number;
		next_burst_cnt = burst_cnt;
		next_rl_cnt = rl_cnt;
		next_symbol_number = symbol_number;
		next_mute_cnt = mute_cnt;
		next_sf_start = 1'b0;
		case (phase)
			OSFM_PRE: begin
				if (sym_end) begin
					if (symbol_number == pre_syms - 4'h1) begin
						next_phase = OSFM_FWD;
						next_symbol_number = 4'h0;
						next_frame_number = 6'h00;
						next_burst_cnt = 6'h00;
					end else begin
						next_symbol_number = symbol_number + 4'h1;
					end
				end
			end
			OSFM_FWD: begin
				if (sym_end) begin
					next_symbol_number = symbol_number + 4'h1;
					if (symbol_number == frame_syms - 4'h1) begin
						next_symbol_number = 4'h0;
						next_burst_cnt = burst_cnt + 6'h01;
						if (frame_number == frame_total - 6'h01) begin
							// Last frame closes the superframe
							next_phase = OSFM_PRE;
							next_sf_index = sf_index + 32'h00000001;
							next_sf_start = 1'b1;
						end else begin
							next_frame_number = frame_number + 6'h01;
							if (tdd_mode && (burst_cnt + 6'h01 == forward_burst_frame_count)) begin
								next_phase = OSFM_MUTE_RL;
								next_rl_cnt = 6'h00;
								next_mute_cnt = 16'h0000;
							end
						end
					end
				end
			end
			OSFM_MUTE_RL: begin
				// Reverse frames first, each rframe_len chips
				next_mute_cnt = mute_cnt + 16'h0001;
				if (mute_cnt == rframe_len - 16'h0001) begin
					next_mute_cnt = 16'h0000;
					next_rl_cnt = rl_cnt + 6'h01;
					if (rl_cnt + 6'h01 == reverse_burst_frame_count) begin
						next_phase = OSFM_MUTE_GF;
					end
				end
			end
			OSFM_MUTE_GF: begin
				// Both switching guards end the mute
				next_mute_cnt = mute_cnt + 16'h0001;
				if (mute_cnt == tg_fwd + tg_rev - 16'h0001) begin
					next_phase = OSFM_FWD;
					next_burst_cnt = 6'h00;
					next_mute_cnt = 16'h0000;
				end
			end
			default: next_phase = OSFM_PRE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase <= OSFM_PRE;
			sf_index <= 32'h00000000;
			frame_number <= 6'h00;
			burst_cnt <= 6'h00;
			rl_cnt <= 6'h00;
			symbol_number <= 4'h0;
			mute_cnt <= 16'h0000;
			sf_start <= 1'b0;
			reg_rdata <= 32'h00000000;
		end else begin
			phase <= next_phase;
			sf_index <= next_sf_index;
			frame_number <= next_frame_number;
			burst_cnt <= next_burst_cnt;
			rl_cnt <= next_rl_cnt;
			symbol_number <= next_symbol_number;
			mute_cnt <= next_mute_cnt;
			sf_start <= next_sf_start;
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered per-subcarrier outputs, one cycle behind the chip count
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			superframe_phase_value <= 12'h000;
			in_preamble <= 1'b1;
			fwd_active <= 1'b0;
			mute <= 1'b0;
			subcarrier <= 13'h0000;
			carrier_number <= 4'h0;
			local_subcarrier <= 13'h0000;
			sc_valid <= 1'b0;
			sc_guard <= 1'b0;
			sc_qguard <= 1'b0;
			sc_usable <= 1'b0;
			sc_zero <= 1'b0;
		end else begin
			superframe_phase_value <= phase_of(sector_identifier, sf_index);
			in_preamble <= (phase == OSFM_PRE);
			fwd_active <= (phase == OSFM_FWD);
			mute <= (phase == OSFM_MUTE_RL) || (phase == OSFM_MUTE_GF);
			subcarrier <= cur_sc;
			carrier_number <= cls_car;
			local_subcarrier <= cls_local;
			sc_valid <= in_data;
			sc_guard <= in_data && cls_guard;
			sc_qguard <= in_data && cls_qguard;
			sc_usable <= in_data && !cls_guard && !cls_qguard;
			sc_zero <= in_data && (cls_guard || cls_qguard);
		end
	end
endmodule : osfm_superframe

// ### tb/osfm_superframe_assertions.sv
// Port checker for the superframe sequencer and subcarrier mapper.
// Assumes it is bound onto osfm_superframe and sees only its ports.
`timescale 1ns/1ps
module osfm_superframe_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sf_start,
	input wire logic [31:0] sf_index,
	input wire logic [11:0] superframe_phase_value,
	input wire logic in_preamble,
	input wire logic fwd_active,
	input wire logic mute,
	input wire logic [5:0] frame_number,
	input wire logic [12:0] subcarrier,
	input wire logic [3:0] carrier_number,
	input wire logic [12:0] local_subcarrier,
	input wire logic sc_valid,
	input wire logic sc_guard,
	input wire logic sc_qguard,
	input wire logic sc_usable,
	input wire logic sc_zero
);
////////////////////////////////////////
// One clock domain; reset masks every check
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
////////////////////////////////////////
// Sequencer order and counters
a_phase_onehot: assert property ($onehot({in_preamble, fwd_active, mute}))
	else $error("sequencer phase not one-hot");
a_sf_preamble: assert property (sf_start |-> ##[0:2] in_preamble)
	else $error("superframe start without preamble");
a_index_step: assert property ($changed(sf_index) |-> sf_index == $past(sf_index) + 32'h1)
	else $error("superframe index jumped");
a_phase_step: assert property ($changed(sf_index) |=>
	superframe_phase_value == $past(superframe_phase_value) + 12'h1)
	else $error("phase value did not follow index");
a_frame_step: assert property ($changed(frame_number) |->
	frame_number == $past(frame_number) + 6'h1 || frame_number == 6'h0)
	else $error("frame number out of sequence");
a_mute_quiet: assert property (mute |-> !sc_valid)
	else $error("subcarriers during mute");
////////////////////////////////////////
// Subcarrier stream and flags
a_sc_first: assert property ($rose(sc_valid) |-> subcarrier == 13'h0000)
	else $error("symbol does not start at subcarrier zero");
a_sc_step: assert property (sc_valid && $past(sc_valid) |-> subcarrier == $past(subcarrier) + 13'h0001)
	else $error("subcarrier index skipped");
a_data_run: assert property ($rose(sc_valid) |-> sc_valid [*8])
	else $error("data part cut short");
a_carrier_edge: assert property (sc_valid && $past(sc_valid) && carrier_number != $past(carrier_number)
	|-> local_subcarrier == 13'h0000 && carrier_number == $past(carrier_number) + 4'h1)
	else $error("carrier boundary wrong");
a_zero_flags: assert property (sc_zero == (sc_guard | sc_qguard))
	else $error("zero flag differs from guard flags");
a_usable_flag: assert property (sc_valid |-> sc_usable != (sc_guard | sc_qguard))
	else $error("usable flag wrong");
endmodule : osfm_superframe_checker
bind osfm_superframe osfm_superframe_checker u_chk (.ref_clk, .rst, .sf_start, .sf_index, .superframe_phase_value,
	.in_preamble, .fwd_active, .mute, .frame_number, .subcarrier, .carrier_number, .local_subcarrier, .sc_valid,
	.sc_guard, .sc_qguard, .sc_usable, .sc_zero);

// ### tb/osfm_dp_model.sv
// Datapath stand-in: silences flagged subcarriers and counts them.
// Assumes the sequencer's registered flag outputs on the same clock.
`timescale 1ns/1ps
module osfm_dp_model import osfm_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sc_valid,
	input wire logic sc_zero,
	output logic [15:0] sample,
	output logic [31:0] n_zero
);
logic [15:0] next_sample;
logic [31:0] next_n_zero;
////////////////////////////////////////
// Flagged subcarriers get no energy; others a pattern that never idles at zero
always_comb begin
	next_sample = 16'h0000;
	next_n_zero = n_zero;
	if (sc_valid && !sc_zero) begin
		next_sample = (n_zero[15:0] ^ 16'hA5A5) | 16'h0001;
	end
	if (sc_valid && sc_zero) begin
		next_n_zero = n_zero + 32'h1;
	end
end
// Registers only
always_ff @(posedge ref_clk) begin
	if (rst) begin
		sample <= 16'h0000;
		n_zero <= 32'h0;
	end else begin
		sample <= next_sample;
		n_zero <= next_n_zero;
	end
end
endmodule : osfm_dp_model

// ### tb/osfm_superframe_bench.sv
// Self-checking bench for the superframe sequencer and subcarrier mapper.
// Assumes the design, checker and datapath model are compiled before it.
`timescale 1ns/1ps
module osfm_superframe_bench import osfm_pkg::*;;
localparam int FFT = 64, LG = 1, GFR = 8, GPR = 6, SYM = 70, FRAMES = 3;
logic ref_clk, rst, reg_wr, reg_rd, sf_start, in_preamble, fwd_active, mute;
logic sc_valid, sc_guard, sc_qguard, sc_usable, sc_zero, rd_d, prev_valid, mute_gap, g, q, was_live, sym_exp;
logic [15:0] dp_sample;
logic [3:0] reg_addr, symbol_number, carrier_number;
logic [31:0] reg_wdata, reg_rdata, sf_index, n_zero, prev_idx, sector;
logic [11:0] superframe_phase_value;
logic [5:0] frame_number;
logic [12:0] subcarrier, local_subcarrier;
logic [31:0] rd_q[$];
int n_mismatch, checks_done, cyc, run, last_rise, sf_last, mute_run, n_mute, nz, car, loc, tdd, mc;
////////////////////////////////////////
osfm_superframe dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sf_start, .sf_index,
	.superframe_phase_value, .in_preamble, .fwd_active, .mute, .frame_number, .symbol_number, .subcarrier,
	.carrier_number, .local_subcarrier, .sc_valid, .sc_guard, .sc_qguard, .sc_usable, .sc_zero);
osfm_dp_model u_dp (.ref_clk, .rst, .sc_valid, .sc_zero, .sample(dp_sample), .n_zero);
// Chip clock
initial begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end
////////////////////////////////////////
task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
	checks_done++;
	if (seen !== exp) begin
		n_mismatch++;
		$display("BAD %s expected %h seen %h", what, exp, seen);
	end
endtask : chk
task automatic report_and_stop();
	if (n_mismatch == 0 && checks_done > 0) begin
		$display("DONE - PASS");
	end else begin
		$display("DONE - FAIL");
	end
	$finish;
endtask : report_and_stop
// Strobe tasks leave one idle edge so no strobe is driven twice in a step
task automatic wr(input logic [3:0] a, input logic [31:0] d);
	@(posedge ref_clk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge ref_clk);
	reg_wr <= 1'b0;
endtask : wr
task automatic rd(input logic [3:0] a, input logic [31:0] exp);
	@(posedge ref_clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	rd_q.push_back(exp);
	@(posedge ref_clk);
	reg_rd <= 1'b0;
endtask : rd
// Expected class of one subcarrier from the configured counts
task automatic cls(input int sc, input logic pre);
	int gc, cs, h;
	gc = pre ? GPR : GFR;
	h = pre ? GPR : GFR / 2;
	cs = mc ? FFT >> LG : FFT;
	g = sc < gc / 2 || sc >= FFT - gc / 2;
	q = 1'b0;
	for (int m = 1; m < (1 << LG); m++) begin
		if (mc && !g && sc >= cs * m - h && sc < cs * m + h) q = 1'b1;
	end
	car = sc / cs;
	loc = sc % cs;
endtask : cls
// Sector, frame counts, burst sizes, guards, FFT size, prefix, windowed guard, mute lengths, then enable
task automatic setup(input logic [31:0] r);
	sector = r & 32'h0000_0FFF;
	wr(4'h1, r);
	rd(4'h1, sector);
	wr(4'h2, 32'h0000_0003);
	wr(4'h3, 32'h0000_0101);
	wr(4'h4, 32'h0006_0008);
	rd(4'h4, 32'h0006_0008);
	wr(4'h5, 32'h0000_0040);
	wr(4'h6, 32'h0004_0004);
	wr(4'h7, 32'h0002_0022);
	wr(4'h8, 32'h0000_0010);
	wr(4'h9, 32'h0005_0003);
	wr(4'h0, 32'h0000_0011 | 32'(tdd << 1) | 32'(mc << 2));
endtask : setup
////////////////////////////////////////
// Watcher: read answers off the queue, then the stream against the model
always @(posedge ref_clk) begin
	cyc++;
	if (cyc > 8000) begin
		n_mismatch++;
		report_and_stop();
	end
	// Read data stands for one cycle only, zero otherwise
	if (rd_d) begin
		chk("read data", reg_rdata, rd_q.pop_front());
	end else if (!rst) begin
		chk("read idle", reg_rdata, 32'h0);
	end
	rd_d <= reg_rd;
	if (rst) begin
		run = 0;
		last_rise = 0;
		sf_last = 0;
		mute_run = 0;
		nz = 0;
		prev_valid = 1'b0;
		mute_gap = 1'b0;
		was_live = 1'b0;
		sym_exp = 1'b0;
	end else begin
		chk("zero count", n_zero, nz);
		// Datapath output lags the flags by one cycle; silenced chips must be zero
		chk("silenced", dp_sample != 16'h0000, was_live);
		if (sc_valid) begin
			cls(subcarrier, in_preamble);
			chk("guard", sc_guard, g);
			chk("quasi guard", sc_qguard, q);
			chk("usable", sc_usable, !(g | q));
			chk("carrier", carrier_number, car);
			chk("local index", local_subcarrier, loc);
			chk("forward flag", fwd_active, !in_preamble);
			if (!in_preamble) chk("frame range", frame_number < FRAMES, 1);
			if (sf_index === prev_idx) chk("phase", superframe_phase_value, (sector + sf_index) & 32'hFFF);
			if (!prev_valid && last_rise != 0 && !mute_gap) chk("symbol period", cyc - last_rise, SYM);
			if (!prev_valid) last_rise = cyc;
			if (!prev_valid) mute_gap = 1'b0;
			// Two symbols per preamble and per frame, so the number alternates
			if (!prev_valid) begin
				chk("symbol number", symbol_number, sym_exp);
				sym_exp = !sym_exp;
			end
			nz += g | q;
			run++;
		end else if (run != 0) begin
			chk("data part", run, FFT);
			run = 0;
		end
		if (mute) begin
			mute_run++;
			mute_gap = 1'b1;
		end else if (mute_run != 0) begin
			chk("mute length", mute_run, 24);
			n_mute++;
			mute_run = 0;
		end
		if (sf_start) begin
			// TDD adds one 24-chip mute after every frame but the last
			if (sf_last != 0) begin
				chk("superframe length", cyc - sf_last, 2 * SYM + FRAMES * 2 * SYM + tdd * (FRAMES - 1) * 24);
			end
			sf_last = cyc;
		end
		was_live = sc_valid && !(g | q);
	end
	prev_idx = sf_index;
	prev_valid = sc_valid;
end
////////////////////////////////////////
// Main sequence: reset values, FDD single carrier, then TDD multi-carrier
initial begin
	rst = 1'b1;
	reg_addr = 4'h0;
	reg_wdata = 32'h0;
	reg_wr = 1'b0;
	reg_rd = 1'b0;
	void'($urandom(96));
	repeat (5) @(posedge ref_clk);
	rst <= 1'b0;
	rd(4'h5, 32'h0000_0200);
	rd(4'h0, 32'h0);
	wr(4'hE, 32'hFFFF_FFFF);
	rd(4'hE, 32'h0);
	chk("idle preamble", in_preamble, 1);
	setup($urandom);
	repeat (1400) @(posedge ref_clk);
	rst <= 1'b1;
	repeat (5) @(posedge ref_clk);
	tdd = 1;
	mc = 1;
	rst <= 1'b0;
	setup(32'h0000_0FFF);
	repeat (2500) @(posedge ref_clk);
	chk("mute seen", n_mute > 0, 1);
	report_and_stop();
end
endmodule : osfm_superframe_bench
